/* pvi_consts.vh */
// Constants for the prioritised vector interrupt unit.
// Included by every design file of the unit; definitions only.
`ifndef PVI_CONSTS_VH
`define PVI_CONSTS_VH

// Source codes presented to the core
`define PVI_NUM_HW 16
`define PVI_CODE_W 5
`define PVI_CODE_BRK 5'h10
`define PVI_CODE_RESET 5'h11

// Vector pairs, low byte at the even address
`define PVI_VEC_BRK 16'h7FFE
`define PVI_VEC_RESET 16'h7FFC
`define PVI_VEC_SERIAL_TX 16'h7FE8
`define PVI_VEC_SERIAL_RX 16'h7FE6
`define PVI_VEC_HIGH_BASE 16'h7FF8
`define PVI_HIGH_FIRST 5'h08

// Priority numbers
`define PVI_PRIO_RESET 5'h00
`define PVI_PRIO_BRK 5'h01

// Processor status bit that blocks dispatch
`define PVI_STATUS_I_BIT 2

// Register offsets
`define PVI_ADDR_W 4
`define PVI_REG_ENA_LO 4'h0
`define PVI_REG_ENA_HI 4'h1
`define PVI_REG_REQ_LO 4'h2
`define PVI_REG_REQ_HI 4'h3
`define PVI_REG_STATE 4'h4
`define PVI_REG_EVT_STAT 4'h5
`define PVI_REG_EVT_CLR 4'h6
`define PVI_REG_EVT_EN 4'h7

// Unit event bits
`define PVI_EVT_W 3
`define PVI_EVT_DISPATCH 0
`define PVI_EVT_OVERRUN 1
`define PVI_EVT_MASKED 2

// Reset values
`define PVI_ENA_RESET 16'h0000
`define PVI_EVT_EN_RESET 3'h0

`endif

/* pvi_arbiter.v */
// Fixed-priority pick among the pending flags, reset and break.
// Pure combinational; flags come from registers in the caller.
`timescale 1ns/1ns
`include "pvi_consts.vh"

module pvi_arbiter #(
  parameter NUM_HW = `PVI_NUM_HW
) (
  // Requests
  input wire [NUM_HW-1:0] i_req,
  input wire i_brk,
  input wire i_rst_pend,
  // Winner
  output reg o_valid,
  output reg [`PVI_CODE_W-1:0] o_code
);

  integer k;

  // Index k carries priority number k+1; break wins its tie with index 0
  always @* begin
    o_valid = 1'b0;
    o_code = `PVI_CODE_BRK;
    if (i_rst_pend) begin
      o_valid = 1'b1;
      o_code = `PVI_CODE_RESET;
    end else if (i_brk) begin
      o_valid = 1'b1;
      o_code = `PVI_CODE_BRK;
    end else begin
      for (k = NUM_HW - 1; k >= 0; k = k - 1) begin
        if (i_req[k]) begin
          o_valid = 1'b1;
          o_code = k[`PVI_CODE_W-1:0];
        end
      end
    end
  end

endmodule

/* pvi_vec_table.v */
// Vector location table: source code in, registered vector pair out.
// Expects the code to be stable for the cycle it is sampled.
`timescale 1ns/1ns
`include "pvi_consts.vh"

module pvi_vec_table (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Lookup
  input wire [`PVI_CODE_W-1:0] i_code,
  output reg [15:0] o_vec_lo_q,
  output reg [15:0] o_vec_hi_q
);

  function [15:0] vec_of;
    input [`PVI_CODE_W-1:0] code;
    begin
      if (code == `PVI_CODE_RESET)
        vec_of = `PVI_VEC_RESET;
      else if (code == `PVI_CODE_BRK)
        vec_of = `PVI_VEC_BRK;
      else if (code < `PVI_HIGH_FIRST)
        vec_of = `PVI_VEC_SERIAL_TX - {10'h000, code, 1'b0};
      else
        vec_of = `PVI_VEC_HIGH_BASE - {10'h000, code - `PVI_HIGH_FIRST, 1'b0};
    end
  endfunction

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_vec_lo_q <= `PVI_VEC_RESET;
      o_vec_hi_q <= `PVI_VEC_RESET | 16'h0001;
    end else begin
      o_vec_lo_q <= vec_of(i_code);
      o_vec_hi_q <= vec_of(i_code) | 16'h0001;
    end
  end

endmodule

/* pvi_top.v */
// Prioritised vector interrupt unit: request flags, masks, dispatch.
// Assumes a core that raises i_vec_ack when it enters the offered handler.
//
// Contract
// - Sixteen hardware sources plus one software break request are accepted.
// - Seventeen source vectors exist, plus a separate reset vector.
// - Status bit 2 set blocks every vector dispatch, hardware or break.
// - A hardware source raises a request only when its enable bit is set.
// - Among pending requests the lowest priority number is dispatched first.
// - An enabled event sets its pending flag and wakes the core.
// - Pending request with flag clear makes the core fetch its vector.
// - A pending flag clears itself when its handler is entered.
// - Break uses vector 7FFE/7FFF with priority number 1.
// - Reset uses vector 7FFC/7FFD at priority 0, above all.
// - Serial transmit empty uses vector 7FE8/7FE9, priority 1.
// - Serial receive ready uses vector 7FE6/7FE7, priority 2.
`timescale 1ns/1ns
`include "pvi_consts.vh"

module pvi_top #(
  parameter NUM_HW = `PVI_NUM_HW
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Interrupt sources, one-cycle pulses
  input wire [NUM_HW-1:0] i_src_evt,
  input wire i_brk_req,
  // Core side
  input wire [7:0] i_cpu_status,
  input wire i_vec_ack,
  output reg o_vec_req_q,
  output wire [`PVI_CODE_W-1:0] o_vec_code_q,
  output wire [15:0] o_vec_lo_addr_q,
  output wire [15:0] o_vec_hi_addr_q,
  output reg o_wake_q,
  // Register port
  input wire [`PVI_ADDR_W-1:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [7:0] o_reg_rdata_q,
  // Unit interrupt
  output reg o_irq_q
);

  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n;

  reg [NUM_HW-1:0] source_enable_mask_q;
  reg [NUM_HW-1:0] pending_request_flags_q;
  reg [NUM_HW-1:0] pending_request_flags_d;
  reg brk_pend_q;
  reg brk_pend_d;
  reg rst_pend_q;
  reg [`PVI_CODE_W-1:0] pres_code_q;
  reg [`PVI_EVT_W-1:0] evt_stat_q;
  reg [`PVI_EVT_W-1:0] evt_stat_d;
  reg [`PVI_EVT_W-1:0] evt_en_q;
  reg [7:0] rdata_d;

  wire [NUM_HW-1:0] evt_accepted;
  wire [NUM_HW-1:0] evt_refused;
  wire [NUM_HW-1:0] ack_clear;
  wire [NUM_HW-1:0] sw_clear;
  wire dispatch_blocked;
  wire win_valid;
  wire [`PVI_CODE_W-1:0] win_code;
  wire [`PVI_CODE_W-1:0] lookup_code;
  wire ack_hw;
  wire ack_brk;
  wire ack_rst;

  // Reset release through two flops
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  assign dispatch_blocked = i_cpu_status[`PVI_STATUS_I_BIT];

  // Event acceptance
  assign evt_accepted = i_src_evt & source_enable_mask_q;
  assign evt_refused = i_src_evt & ~source_enable_mask_q;

  // Handler entry for the offered source
  assign ack_hw = i_vec_ack & o_vec_req_q & (pres_code_q < NUM_HW);
  assign ack_brk = i_vec_ack & o_vec_req_q & (pres_code_q == `PVI_CODE_BRK);
  assign ack_rst = i_vec_ack & o_vec_req_q & (pres_code_q == `PVI_CODE_RESET);

  genvar g;
  generate
    for (g = 0; g < NUM_HW; g = g + 1) begin : g_clr
      assign ack_clear[g] = ack_hw & (pres_code_q == g);
      assign sw_clear[g] = i_reg_wr & ~i_reg_wdata[g % 8] &
        (i_reg_addr == ((g < 8) ? `PVI_REG_REQ_LO : `PVI_REG_REQ_HI));
    end
  endgenerate

  // Flags: a new event wins over any clear in the same cycle
  always @* begin
    pending_request_flags_d = (pending_request_flags_q & ~ack_clear & ~sw_clear) | evt_accepted;
    brk_pend_d = (brk_pend_q & ~ack_brk) | i_brk_req;
  end

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_request_flags_q <= {NUM_HW{1'b0}};
      brk_pend_q <= 1'b0;
      rst_pend_q <= 1'b1;
    end else begin
      pending_request_flags_q <= pending_request_flags_d;
      brk_pend_q <= brk_pend_d;
      if (ack_rst)
        rst_pend_q <= 1'b0;
    end
  end

  // Wake from either wait mode on any accepted event
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_wake_q <= 1'b0;
    end else begin
      o_wake_q <= (|evt_accepted) | i_brk_req;
    end
  end

  pvi_arbiter #(
    .NUM_HW(NUM_HW)
  ) u_arb (
    .i_req(pending_request_flags_q),
    .i_brk(brk_pend_q),
    .i_rst_pend(rst_pend_q),
    .o_valid(win_valid),
    .o_code(win_code)
  );

  assign lookup_code = win_code;

  pvi_vec_table u_vec (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_code(lookup_code),
    .o_vec_lo_q(o_vec_lo_addr_q),
    .o_vec_hi_q(o_vec_hi_addr_q)
  );

  // Offer the winner; the cycle of an ack always withdraws the offer
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_vec_req_q <= 1'b0;
      pres_code_q <= `PVI_CODE_RESET;
    end else begin
      pres_code_q <= win_code;
      o_vec_req_q <= win_valid & ~i_vec_ack &
        (rst_pend_q | ~dispatch_blocked);
    end
  end

  assign o_vec_code_q = pres_code_q;

  // Unit events: set wins over clear
  always @* begin
    evt_stat_d = evt_stat_q;
    if (i_reg_wr && i_reg_addr == `PVI_REG_EVT_CLR)
      evt_stat_d = evt_stat_q & ~i_reg_wdata[`PVI_EVT_W-1:0];
    if (ack_hw | ack_brk)
      evt_stat_d[`PVI_EVT_DISPATCH] = 1'b1;
    if (|(evt_accepted & pending_request_flags_q))
      evt_stat_d[`PVI_EVT_OVERRUN] = 1'b1;
    if (|evt_refused)
      evt_stat_d[`PVI_EVT_MASKED] = 1'b1;
  end

  // Writable registers
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      source_enable_mask_q <= `PVI_ENA_RESET;
      evt_en_q <= `PVI_EVT_EN_RESET;
      evt_stat_q <= {`PVI_EVT_W{1'b0}};
    end else begin
      evt_stat_q <= evt_stat_d;
      if (i_reg_wr) begin
        case (i_reg_addr)
          `PVI_REG_ENA_LO: source_enable_mask_q[7:0] <= i_reg_wdata;
          `PVI_REG_ENA_HI: source_enable_mask_q[15:8] <= i_reg_wdata;
          `PVI_REG_EVT_EN: evt_en_q <= i_reg_wdata[`PVI_EVT_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // Read path, data in the cycle after the strobe
  always @* begin
    rdata_d = 8'h00;
    case (i_reg_addr)
      `PVI_REG_ENA_LO: rdata_d = source_enable_mask_q[7:0];
      `PVI_REG_ENA_HI: rdata_d = source_enable_mask_q[15:8];
      `PVI_REG_REQ_LO: rdata_d = pending_request_flags_q[7:0];
      `PVI_REG_REQ_HI: rdata_d = pending_request_flags_q[15:8];
      `PVI_REG_STATE: rdata_d = {o_vec_req_q, brk_pend_q, 1'b0, pres_code_q};
      `PVI_REG_EVT_STAT: rdata_d = {5'h00, evt_stat_q};
      `PVI_REG_EVT_EN: rdata_d = {5'h00, evt_en_q};
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata_q <= 8'h00;
      o_irq_q <= 1'b0;
    end else begin
      o_reg_rdata_q <= i_reg_rd ? rdata_d : 8'h00;
      o_irq_q <= |(evt_stat_d & evt_en_q);
    end
  end

endmodule

/* pvi_core.sv */
// Core model: enters the offered handler after a set wait.
// Watches the unit's offer; answers with a one-cycle enter pulse.
`timescale 1ns/1ns
module pvi_core (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Offer and pacing
  input wire i_req,
  input wire [3:0] i_wait,
  output reg o_ack
);
  reg [3:0] cnt;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 4'h0;
      o_ack <= 1'b0;
    end else begin
      o_ack <= i_req && !o_ack && cnt == i_wait;
      cnt <= (i_req && !o_ack && cnt != i_wait) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule

/* pvi_chk.sv */
// Port checker for the interrupt unit.
// Bound into pvi_top; sees its ports only.
`timescale 1ns/1ns
module pvi_chk #(
  parameter NUM_HW = 16
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire [NUM_HW-1:0] i_src_evt,
  input wire i_brk_req,
  input wire [7:0] i_cpu_status,
  input wire i_vec_ack,
  input wire o_vec_req_q,
  input wire [4:0] o_vec_code_q,
  input wire [15:0] o_vec_lo_addr_q,
  input wire [15:0] o_vec_hi_addr_q,
  input wire o_wake_q
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire offer = o_vec_req_q && o_vec_code_q != 5'h11;
  sequence s_ack;
    o_vec_req_q && i_vec_ack;
  endsequence
  sequence s_wake;
    o_wake_q && !i_cpu_status[2] && !i_vec_ack;
  endsequence
  AST_RST_VEC: assert property (o_vec_req_q && o_vec_code_q == 5'h11 |-> o_vec_lo_addr_q == 16'h7FFC)
    else $error("reset vector wrong");
  AST_BRK_VEC: assert property (o_vec_req_q && o_vec_code_q == 5'h10 |-> o_vec_lo_addr_q == 16'h7FFE)
    else $error("break vector wrong");
  AST_TX_VEC: assert property (o_vec_req_q && o_vec_code_q == 5'h00 |-> o_vec_lo_addr_q == 16'h7FE8)
    else $error("transmit vector wrong");
  AST_RX_VEC: assert property (o_vec_req_q && o_vec_code_q == 5'h01 |-> o_vec_lo_addr_q == 16'h7FE6)
    else $error("receive vector wrong");
  AST_PAIR: assert property (o_vec_req_q |-> o_vec_hi_addr_q == (o_vec_lo_addr_q | 16'h0001) && !o_vec_lo_addr_q[0])
    else $error("vector pair wrong");
  AST_BLOCK: assert property (i_cpu_status[2] [*3] |-> !offer)
    else $error("offer while disabled");
  AST_ACK: assert property (s_ack |=> !o_vec_req_q)
    else $error("offer kept after entry");
  AST_WAKE_SRC: assert property (o_wake_q |-> $past(|i_src_evt || i_brk_req))
    else $error("wake without event");
  AST_WAKE_OFFER: assert property (s_wake |-> ##[1:2] o_vec_req_q)
    else $error("no offer after wake");
endmodule
bind pvi_top pvi_chk #(.NUM_HW(NUM_HW)) chk (.i_clk, .i_rst_n, .i_src_evt, .i_brk_req, .i_cpu_status,
  .i_vec_ack, .o_vec_req_q, .o_vec_code_q, .o_vec_lo_addr_q, .o_vec_hi_addr_q, .o_wake_q);

/* testbench.sv */
// Testbench for the prioritised vector interrupt unit.
// Drives sources and registers; a core model enters handlers.
`timescale 1ns/1ns
module testbench;
  reg i_clk = 1'b0;
  reg i_rst_n = 1'b0;
  reg [15:0] src = 16'h0000;
  reg brk = 1'b0;
  reg [7:0] stat = 8'h04;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [3:0] wt = 4'h0;
  wire ack, req, wake, irq;
  wire [4:0] code;
  wire [15:0] lo, hi;
  wire [7:0] rdata;
  integer n_mismatch = 0;
  integer checks_done = 0;
  reg [36:0] got [$];
  always #25 i_clk = ~i_clk;
  pvi_top uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_src_evt(src), .i_brk_req(brk), .i_cpu_status(stat),
    .i_vec_ack(ack), .o_vec_req_q(req), .o_vec_code_q(code), .o_vec_lo_addr_q(lo), .o_vec_hi_addr_q(hi),
    .o_wake_q(wake), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata_q(rdata), .o_irq_q(irq));
  pvi_core core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .i_wait(wt), .o_ack(ack));
  // Log of entered handlers
  always @(posedge i_clk) if (req && ack) got.push_back({code, lo, hi});
  task chk(input [36:0] seen, input [36:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  function [36:0] ent(input [4:0] k);
    reg [15:0] v;
    begin
      v = k < 8 ? 16'h7FE8 - {k, 1'b0} : 16'h7FF8 - {k - 5'h08, 1'b0};
      ent = {k, v, v | 16'h0001};
    end
  endfunction
  task wr_reg(input [3:0] a, input [7:0] v);
    begin
      @(posedge i_clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
    end
  endtask
  task rdc(input [3:0] a, input [7:0] e);
    begin
      @(posedge i_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
    end
  endtask
  task pulse(input [15:0] e, input b);
    begin
      @(posedge i_clk);
      src <= e;
      brk <= b;
      @(posedge i_clk);
      src <= 16'h0000;
      brk <= 1'b0;
      #1;
    end
  endtask
  task wait_n(input integer n);
    integer i;
    begin
      for (i = 0; i < 300 && got.size() < n; i = i + 1) @(posedge i_clk);
      #1;
    end
  endtask
  task t_reset;
    begin
      wait_n(1);
      chk(got[0], {5'h11, 16'h7FFC, 16'h7FFD});
      got.delete();
      $display("test reset done");
    end
  endtask
  task t_mask;
    begin
      @(posedge i_clk);
      stat <= 8'h00;
      wt <= 4'h3;
      wr_reg(4'h0, 8'hF7);
      pulse(16'h0008, 1'b0);
      chk(wake, 1'b0);
      rdc(4'h2, 8'h00);
      pulse(16'h0004, 1'b0);
      chk(wake, 1'b1);
      wait_n(1);
      chk(got[0], ent(5'h02));
      got.delete();
      wr_reg(4'h0, 8'hFF);
      wr_reg(4'h1, 8'hFF);
      $display("test mask done");
    end
  endtask
  task t_prio;
    integer k;
    begin
      @(posedge i_clk);
      stat <= 8'h04;
      wt <= 4'h0;
      pulse(16'hFFFF, 1'b1);
      repeat (6) @(posedge i_clk);
      chk(got.size(), 0);
      rdc(4'h2, 8'hFF);
      rdc(4'h3, 8'hFF);
      @(posedge i_clk);
      stat <= 8'h00;
      wait_n(17);
      chk(got[0], {5'h10, 16'h7FFE, 16'h7FFF});
      for (k = 0; k < 16; k = k + 1) chk(got[k + 1], ent(k[4:0]));
      got.delete();
      $display("test priority done");
    end
  endtask
  task t_clear;
    begin
      @(posedge i_clk);
      stat <= 8'h04;
      pulse(16'h0220, 1'b0);
      wr_reg(4'h2, 8'hDF);
      wr_reg(4'h3, 8'hFF);
      rdc(4'h2, 8'h00);
      rdc(4'h3, 8'h02);
      @(posedge i_clk);
      stat <= 8'h00;
      wait_n(1);
      chk(got[0], ent(5'h09));
      repeat (4) @(posedge i_clk);
      chk(got.size(), 1);
      rdc(4'h3, 8'h00);
      $display("test clear done");
    end
  endtask
  task t_irq;
    begin
      rdc(4'h5, 8'h05);
      wr_reg(4'h7, 8'h01);
      @(posedge i_clk);
      #1;
      chk(irq, 1'b1);
      wr_reg(4'h6, 8'h07);
      @(posedge i_clk);
      #1;
      chk(irq, 1'b0);
      rdc(4'h5, 8'h00);
      rdc(4'h8, 8'h00);
      // Second event on a still pending source flags an overrun
      @(posedge i_clk);
      stat <= 8'h04;
      pulse(16'h0001, 1'b0);
      pulse(16'h0001, 1'b0);
      rdc(4'h5, 8'h02);
      rdc(4'h2, 8'h01);
      wr_reg(4'h2, 8'hFE);
      wr_reg(4'h6, 8'h07);
      rdc(4'h2, 8'h00);
      rdc(4'h5, 8'h00);
      $display("test irq done");
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset;
    t_mask;
    t_prio;
    t_clear;
    t_irq;
    conclude;
  end
  // Watchdog, far beyond the 150 or so cycles needed
  initial begin
    #500000;
    n_mismatch = n_mismatch + 1;
    conclude;
  end
endmodule
